// >>> shsp_host_model.sv
// host controller model driving the i2c and spi pins
// assumes: sda_w is the resolved open-drain line with a pull-up
`timescale 1ns/1ps
module shsp_host_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_w,
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // ==========
  // i2c, quarter bit of 500 ns keeps each phase above 4 cycles
  task automatic bit_io(input logic b, output logic q);
    #500 sda_drv = b;
    #500 scl = 1'b1;
    #500 q = sda_w;
    #500 scl = 1'b0;
  endtask
  task automatic start();
    #500 sda_drv = 1'b1;
    #500 scl = 1'b1;
    #500 sda_drv = 1'b0;
    #500 scl = 1'b0;
  endtask
  task automatic stop();
    #500 sda_drv = 1'b0;
    #500 scl = 1'b1;
    #500 sda_drv = 1'b1;
  endtask
  task automatic byte_io(input logic [7:0] b, input logic ak, output logic [7:0] r,
                         output logic q);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ak, q);
  endtask
  // ==========
  // spi mode 0, with four stray sclk toggles before select falls in each frame
  task automatic frame(input logic [31:0] w, output logic [31:0] r);
    repeat (4) begin
      #62.5 sclk = ~sclk;
      mosi = ~mosi;
    end
    #300 ss_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      #62.5 sclk = 1'b1;
      r[i] = miso;
      #62.5 sclk = 1'b0;
    end
    #300 ss_n = 1'b1;
    mosi = ~mosi;
    #700;
  endtask
endmodule // shsp_host_model

// >>> shsp_params.svh
// named offsets, field positions and codes for the sensor host serial port
// assumes: included by bare name from the design file and the testbench
`ifndef SHSP_PARAMS_SVH
`define SHSP_PARAMS_SVH

// register map
`define SHSP_REG_SRC_SEL0   8'h1a
`define SHSP_REG_SRC_SEL1   8'h1b
`define SHSP_REG_DEVSTAT    8'h61
`define SHSP_REG_S0_LO      8'h62
`define SHSP_REG_S0_HI      8'h63
`define SHSP_REG_S1_LO      8'h64
`define SHSP_REG_S1_HI      8'h65
`define SHSP_REG_TS_TOP     8'h69
`define SHSP_RO_LO          8'h60
`define SHSP_RO_HI          8'h6f
`define SHSP_REG_RESET      8'h00

// source select register fields
`define SHSP_SRC_EN_BIT     7
`define SHSP_SRC_TAG_MSB    2

// spi command codes and status
`define SHSP_CMD_WRITE      4'h8
`define SHSP_CMD_READ       4'hc
`define SHSP_CMD_ERR        4'h0
`define SHSP_ST_ERR         2'h3
`define SHSP_FRAME_BITS     6'h20
`define SHSP_LAST_BIT_CNT   6'h1f

// crc settings
`define SHSP_CRC_SEED       8'hff
`define SHSP_CRC_POLY       8'h2f

// i2c byte length
`define SHSP_BYTE_BITS      4'h8

`endif

// >>> shsp_pkg.sv
// types shared by the sensor host serial port
// assumes: shsp_params.svh on the include path
package shsp_pkg;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_REG, I2C_REG_ACK,
    I2C_WDATA, I2C_WDATA_ACK, I2C_RDATA, I2C_RDATA_ACK
  } shsp_i2c_e;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_s3;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_s3;
    logic       ss_s1;
    logic       ss_s2;
    logic       ss_s3;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_seen;
    shsp_i2c_e  st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic       rw;
    logic       more;
    logic [7:0] ptr;
    logic       sda_oe;
    logic [31:0] resp;
  } shsp_sys_s;

  typedef struct packed {
    logic [31:0] rx;
    logic [31:0] word;
    logic        tog;
  } shsp_spi_s;

endpackage

// >>> shsp_props.sv
// checker on the serial port pins
// assumes: bound into the top module, clk_sys running
`timescale 1ns/1ps
module shsp_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic spi_ss_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  // ==========
  // cycle counters, saturating so long idle spans stay legal
  logic [3:0] ss_hi_q;
  logic [3:0] lo_q;
  logic [3:0] hi_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ss_hi_q <= 4'h0;
      lo_q    <= 4'h0;
      hi_q    <= 4'h0;
    end else begin
      ss_hi_q <= spi_ss_n ? ss_hi_q + {3'h0, ss_hi_q != 4'hf} : 4'h0;
      lo_q    <= scl_in ? 4'h0 : lo_q + {3'h0, lo_q != 4'hf};
      hi_q    <= scl_in ? hi_q + {3'h0, hi_q != 4'hf} : 4'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========
  // properties
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od)
    else $error("sda driven high");
  property p_oe_scl; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_scl: assert property (p_oe_scl)
    else $error("sda moved with scl high");
  // synchroniser lag: a change lands 2 to 5 cycles after the scl fall
  property p_oe_lag; $changed(sda_oe) |-> lo_q inside {[4'h2:4'h5]}; endproperty
  a_oe_lag: assert property (p_oe_lag)
    else $error("sda change off its slot");
  property p_ack_hold; $rose(sda_oe) |-> sda_oe [*6]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("sda pull too short");
  property p_oe_idle; hi_q == 4'hf |-> !sda_oe; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("sda held on idle bus");
  property p_rst_quiet; $fell(rst) |-> !sda_oe && !spi_miso; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs busy after reset");
  property p_miso_oe; spi_miso_oe == !spi_ss_n; endproperty
  a_miso_oe: assert property (p_miso_oe)
    else $error("miso enable wrong");
  property p_miso_idle; spi_ss_n && $changed(spi_miso) |-> ss_hi_q < 4'h8; endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("miso moved while idle");
endmodule // shsp_props

bind shsp_sensor_host_serial_port shsp_props i_props (
  .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .spi_ss_n(spi_ss_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

// >>> shsp_sensor_host_serial_port.sv
// sensor host serial port: i2c client and 32-bit spi client onto a byte register map
// assumes: the signal chain writes sample bytes over the snap port on clk_sys;
// spi_sclk is the host's clock; stray edges while spi_ss_n is high are ignored
`timescale 1ns/1ps
`include "shsp_params.svh"

module shsp_sensor_host_serial_port #(
  parameter logic [6:0] CLIENT_ADDR = 7'h2a  // arbitrary default
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       spi_sclk,
  input  wire logic       spi_ss_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  input  wire logic       snap_wr_en,
  input  wire logic [7:0] snap_wr_addr,
  input  wire logic [7:0] snap_wr_data,
  input  wire logic [1:0] basic_state_in,
  input  wire logic [1:0] detailed_state_in
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = `SHSP_CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ `SHSP_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic is_ro(input logic [7:0] a);
    return (a >= `SHSP_RO_LO) && (a <= `SHSP_RO_HI);
  endfunction

  // ==========================================================================
  // register map
  // ==========================================================================
  logic [7:0] regs_q [256];
  logic       usr_we;
  logic [7:0] usr_wa;
  logic [7:0] usr_wd;
  logic       en0;
  logic       en1;
  logic [2:0] tag0;
  logic [2:0] tag1;

  assign en0  = regs_q[`SHSP_REG_SRC_SEL0][`SHSP_SRC_EN_BIT];
  assign en1  = regs_q[`SHSP_REG_SRC_SEL1][`SHSP_SRC_EN_BIT];
  assign tag0 = regs_q[`SHSP_REG_SRC_SEL0][`SHSP_SRC_TAG_MSB:0];
  assign tag1 = regs_q[`SHSP_REG_SRC_SEL1][`SHSP_SRC_TAG_MSB:0];

  // read-only region belongs to the signal chain; host writes there are dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        regs_q[i] <= `SHSP_REG_RESET;
      end
    end else if (clk_en) begin
      if (snap_wr_en && is_ro(snap_wr_addr)) begin
        regs_q[snap_wr_addr] <= snap_wr_data;
      end
      if (usr_we && !is_ro(usr_wa)) begin
        regs_q[usr_wa] <= usr_wd;
      end
    end
  end

  // read pointer advance with sensor data wrap-around
  function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic e0,
                                          input logic e1);
    logic [7:0] n;
    n = p + 8'h01;
    if (e0 && e1 && p == `SHSP_REG_TS_TOP) begin
      n = `SHSP_REG_DEVSTAT;
    end else if (e0 && !e1 && p == `SHSP_REG_S0_HI) begin
      n = `SHSP_REG_DEVSTAT;
    end else if (!e0 && e1 && p == `SHSP_REG_S1_HI) begin
      n = `SHSP_REG_DEVSTAT;
    end
    return n;
  endfunction

  // ==========================================================================
  // spi link domain (host clock)
  // ==========================================================================
  shsp_pkg::shsp_spi_s spi_q;
  shsp_pkg::shsp_spi_s spi_d;
  logic [5:0]          bit_cnt_q;
  logic [4:0]          out_idx_q;
  logic                frame_rst;
  shsp_pkg::shsp_sys_s q;

  // select high clears the frame counters, so stray clocks between frames
  // never shift a bit in or out
  assign frame_rst = rst | spi_ss_n;

  always_ff @(posedge spi_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 6'h00;
    end else if (bit_cnt_q != `SHSP_FRAME_BITS) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // output bit moves on the falling edge, so it is settled for the next rise
  always_ff @(negedge spi_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_idx_q <= 5'h00;
    end else if (out_idx_q != 5'h1f) begin
      out_idx_q <= out_idx_q + 5'h01;
    end
  end

  always_comb begin
    spi_d = spi_q;
    if (!spi_ss_n && bit_cnt_q != `SHSP_FRAME_BITS) begin
      spi_d.rx = {spi_q.rx[30:0], spi_mosi};
      if (bit_cnt_q == `SHSP_LAST_BIT_CNT) begin
        spi_d.word = {spi_q.rx[30:0], spi_mosi};
        spi_d.tog  = ~spi_q.tog;
      end
    end
  end

  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      spi_q <= '0;
    end else begin
      spi_q <= spi_d;
    end
  end

  // response word is stable from the previous frame's end until this frame
  assign spi_miso    = q.resp[5'h1f - out_idx_q];
  assign spi_miso_oe = ~spi_ss_n;

  // ==========================================================================
  // system domain: synchronisers, i2c client, spi decoder
  // ==========================================================================
  shsp_pkg::shsp_sys_s d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        ss_rise;
  logic [31:0] w;
  logic [3:0]  cmd;
  logic [3:0]  echo;
  logic        bad;
  logic        no_data;
  logic [23:0] body;
  logic [15:0] pair;
  logic [15:0] smp;
  logic [7:0]  ra;
  logic        spi_we;
  logic [7:0]  spi_wa;
  logic        i2c_we;

  assign scl_rise = q.scl_s2 & ~q.scl_s3;
  assign scl_fall = ~q.scl_s2 & q.scl_s3;
  assign start_c  = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
  assign stop_c   = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
  assign ss_rise  = q.ss_s2 & ~q.ss_s3;
  assign w        = spi_q.word;
  assign cmd      = w[31:28];
  assign echo     = {cmd[0], cmd[3:1]};
  assign ra       = w[23:16];
  assign pair     = {regs_q[{ra[7:1], 1'b1}], regs_q[{ra[7:1], 1'b0}]};

  // spi frame decode, done once select has gone high
  always_comb begin
    bad     = (q.tog_s2 == q.tog_seen) || (crc8(w[31:8]) != w[7:0]);
    no_data = 1'b0;
    smp     = 16'h0000;
    spi_we  = 1'b0;
    spi_wa  = ra;
    body    = 24'h000000;
    if (cmd[0]) begin
      if (w[27:8] != 20'h00000) begin
        bad = 1'b1;
      end
      if (en0 && tag0 == cmd[3:1]) begin
        smp = {regs_q[`SHSP_REG_S0_HI], regs_q[`SHSP_REG_S0_LO]};
      end else if (en1 && tag1 == cmd[3:1]) begin
        smp = {regs_q[`SHSP_REG_S1_HI], regs_q[`SHSP_REG_S1_LO]};
      end else begin
        no_data = 1'b1;
      end
      body = {echo, basic_state_in, smp[15:4], 4'h0, detailed_state_in};
    end else if (cmd == `SHSP_CMD_WRITE || cmd == `SHSP_CMD_READ) begin
      if (w[27:24] != 4'h0) begin
        bad = 1'b1;
      end
      spi_we = (cmd == `SHSP_CMD_WRITE) && !bad && ss_rise;
      body   = {echo, basic_state_in, 2'b00, pair};
    end else begin
      bad = 1'b1;
    end
    if (bad || no_data) begin
      body = {`SHSP_CMD_ERR, `SHSP_ST_ERR, 12'h000, 4'h0, detailed_state_in};
    end
  end

  // spi write wins a same-cycle clash with an i2c write
  always_comb begin
    usr_we = spi_we | i2c_we;
    usr_wa = spi_we ? spi_wa : q.ptr;
    usr_wd = spi_we ? w[15:8] : q.shift;
  end

  // i2c client; every byte is finished inside its ack pulse, scl is never held
  always_comb begin
    d        = q;
    i2c_we   = 1'b0;
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.ss_s1  = spi_ss_n;
    d.ss_s2  = q.ss_s1;
    d.ss_s3  = q.ss_s2;
    d.tog_s1 = spi_q.tog;
    d.tog_s2 = q.tog_s1;
    if (ss_rise) begin
      d.tog_seen = q.tog_s2;
      d.resp     = {body, crc8(body)};
    end
    if (start_c) begin
      d.st     = shsp_pkg::I2C_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.st     = shsp_pkg::I2C_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        shsp_pkg::I2C_IDLE: begin
          d.sda_oe = 1'b0;
        end
        shsp_pkg::I2C_ADDR, shsp_pkg::I2C_REG, shsp_pkg::I2C_WDATA: begin
          if (scl_rise) begin
            d.shift  = {q.shift[6:0], q.sda_s2};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == `SHSP_BYTE_BITS) begin
            d.sda_oe = 1'b1;
            d.bitcnt = 4'h0;
            if (q.st == shsp_pkg::I2C_ADDR) begin
              d.rw = q.shift[0];
              if (q.shift[7:1] == CLIENT_ADDR) begin
                d.st = shsp_pkg::I2C_ADDR_ACK;
              end else begin
                d.st     = shsp_pkg::I2C_IDLE;
                d.sda_oe = 1'b0;
              end
            end else if (q.st == shsp_pkg::I2C_REG) begin
              d.ptr = q.shift;
              d.st  = shsp_pkg::I2C_REG_ACK;
            end else begin
              i2c_we = 1'b1;
              d.st   = shsp_pkg::I2C_WDATA_ACK;
            end
          end
        end
        shsp_pkg::I2C_ADDR_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              d.st     = shsp_pkg::I2C_RDATA;
              d.shift  = regs_q[q.ptr];
              d.sda_oe = ~regs_q[q.ptr][7];
            end else begin
              d.st     = shsp_pkg::I2C_REG;
              d.sda_oe = 1'b0;
            end
          end
        end
        shsp_pkg::I2C_REG_ACK: begin
          if (scl_fall) begin
            d.st     = shsp_pkg::I2C_WDATA;
            d.sda_oe = 1'b0;
          end
        end
        shsp_pkg::I2C_WDATA_ACK: begin
          if (scl_fall) begin
            d.ptr    = q.ptr + 8'h01;
            d.st     = shsp_pkg::I2C_WDATA;
            d.sda_oe = 1'b0;
          end
        end
        shsp_pkg::I2C_RDATA: begin
          if (scl_rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (q.bitcnt == `SHSP_BYTE_BITS) begin
              d.st     = shsp_pkg::I2C_RDATA_ACK;
              d.sda_oe = 1'b0;
            end else begin
              d.shift  = {q.shift[6:0], 1'b1};
              d.sda_oe = ~q.shift[6];
            end
          end
        end
        shsp_pkg::I2C_RDATA_ACK: begin
          if (scl_rise) begin
            d.more = ~q.sda_s2;
            d.ptr  = next_ptr(q.ptr, en0, en1);
          end else if (scl_fall) begin
            d.bitcnt = 4'h0;
            if (q.more) begin
              d.st     = shsp_pkg::I2C_RDATA;
              d.shift  = regs_q[q.ptr];
              d.sda_oe = ~regs_q[q.ptr][7];
            end else begin
              d.st     = shsp_pkg::I2C_IDLE;
              d.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          d.st     = shsp_pkg::I2C_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.ss_s1  <= 1'b1;
      q.ss_s2  <= 1'b1;
      q.ss_s3  <= 1'b1;
      q.st     <= shsp_pkg::I2C_IDLE;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // open drain: only ever pulls low, clock line is never touched
  assign sda_out = 1'b0;
  assign sda_oe  = q.sda_oe;

endmodule // shsp_sensor_host_serial_port

// >>> shsp_sensor_host_serial_port_tb.sv
// self-checking bench for the sensor host serial port
// assumes: host model on the pins, sample bytes loaded over the snap port
`timescale 1ns/1ps
`include "shsp_params.svh"
module shsp_sensor_host_serial_port_tb;
  localparam logic [6:0] ADDR = 7'h2a; // arbitrary
  localparam logic [1:0] BS = 2'h1;
  localparam logic [1:0] DS = 2'h2;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b0;
  logic        snap_wr_en = 1'b0;
  logic [7:0]  snap_wr_addr = 8'h00;
  logic [7:0]  snap_wr_data = 8'h00;
  logic        scl, sda_drv, sclk, ss_n, mosi, sda_out, sda_oe, miso, miso_oe, s;
  logic [7:0]  x;
  logic [31:0] r, e;
  logic [15:0] tbl [7] = '{16'h615a, 16'h6234, 16'h6312, 16'h64cd, 16'h65ab, 16'h6866, 16'h6977};
  int          err_total = 0;
  int          checked = 0;
  wire         sda_w = sda_drv & ~sda_oe;
  always #50 clk_sys = ~clk_sys;
  shsp_sensor_host_serial_port #(.CLIENT_ADDR(ADDR)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .spi_sclk(sclk), .spi_ss_n(ss_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .snap_wr_en(snap_wr_en),
    .snap_wr_addr(snap_wr_addr), .snap_wr_data(snap_wr_data), .basic_state_in(BS),
    .detailed_state_in(DS));
  shsp_host_model i_host (.scl(scl), .sda_drv(sda_drv), .sda_w(sda_w), .sclk(sclk),
    .ss_n(ss_n), .mosi(mosi), .miso(miso));
  // ==========
  // helpers
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
    checked++;
    if (g !== ex) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, ex, g);
    end
  endtask
  function automatic logic [31:0] mk(input logic [23:0] d);
    logic [7:0] c;
    c = `SHSP_CRC_SEED;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SHSP_CRC_POLY : 8'h00);
    return {d, c};
  endfunction
  task automatic spi(input logic [23:0] d);
    i_host.frame(mk(d), r);
  endtask
  task automatic snap(input logic [15:0] t);
    @(posedge clk_sys);
    #2 snap_wr_en = 1'b1;
    snap_wr_addr = t[15:8];
    snap_wr_data = t[7:0];
    @(posedge clk_sys);
    #2 snap_wr_en = 1'b0;
  endtask
  task automatic i2c_wr(input logic [7:0] a, input logic [15:0] d);
    i_host.start();
    i_host.byte_io({ADDR, 1'b0}, 1'b1, x, s);
    chk("ack addr", 32'h0, {31'h0, s});
    i_host.byte_io(a, 1'b1, x, s);
    chk("ack reg", 32'h0, {31'h0, s});
    for (int i = 1; i >= 0; i--) begin
      i_host.byte_io(d[8*i+:8], 1'b1, x, s);
      chk("ack data", 32'h0, {31'h0, s});
    end
    i_host.stop();
  endtask
  task automatic i2c_rd(input logic [7:0] a, input int n, input logic [31:0] ex);
    i_host.start();
    i_host.byte_io({ADDR, 1'b0}, 1'b1, x, s);
    i_host.byte_io(a, 1'b1, x, s);
    i_host.start();
    i_host.byte_io({ADDR, 1'b1}, 1'b1, x, s);
    chk("ack rd", 32'h0, {31'h0, s});
    for (int i = n - 1; i >= 0; i--) begin
      i_host.byte_io(8'hff, i == 0, x, s);
      chk("rd byte", {24'h0, ex[8*i+:8]}, {24'h0, x});
    end
    i_host.stop();
  endtask
  // ==========
  // tests
  initial begin
    // a real rising edge on rst, so the link-clock flops are reset before sclk runs
    #2 rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    // keep every pin change off the clk_sys sampling edge
    #2;
    i2c_wr(8'h1a, 16'h8001);
    foreach (tbl[i]) snap(tbl[i]);
    i2c_rd(8'h61, 4, 32'h5a34125a);
    i_host.start();
    i_host.byte_io({ADDR ^ 7'h01, 1'b0}, 1'b1, x, s);
    chk("nack", 32'h1, {31'h0, s});
    i_host.stop();
    spi({4'hc, 4'h0, 8'h1a, 8'h00});
    spi({4'h8, 4'h0, 8'h1b, 8'h81});
    chk("rd rsp", mk({4'h6, BS, 2'h0, 8'h01, 8'h80}), r);
    i_host.frame(mk({4'h8, 4'h0, 8'h1a, 8'h00}) ^ 32'h1, r);
    chk("wr rsp", mk({4'h4, BS, 2'h0, 8'h01, 8'h80}), r);
    spi({4'h1, 4'h1, 16'h0});
    chk("crc err", mk({4'h0, 2'h3, 16'h0, DS}), r);
    spi({4'hc, 4'h0, 8'h1a, 8'h00});
    chk("fix err", mk({4'h0, 2'h3, 16'h0, DS}), r);
    e = mk({4'h6, BS, 2'h0, 8'h81, 8'h80});
    for (int c = 0; c < 16; c++) begin
      spi({c[3:0], 20'h0});
      chk("cmd rsp", e, r);
      e = mk({4'h0, 2'h3, 16'h0, DS});
      if (c == 8 || c == 12) e = mk({1'b0, c[3:1], BS, 2'h0, 16'h0});
      if (c == 1) e = mk({1'b1, c[3:1], BS, 12'h123, 4'h0, DS});
      if (c == 3) e = mk({1'b1, c[3:1], BS, 12'habc, 4'h0, DS});
    end
    spi({4'hc, 4'h0, 8'h1a, 8'h00});
    chk("cmd rsp", e, r);
    i2c_rd(8'h68, 3, 32'h0066775a);
    i2c_wr(8'h1a, 16'h0081);
    i2c_rd(8'h64, 3, 32'h00cdab5a);
    i2c_wr(8'h1a, 16'h0001);
    i2c_wr(8'hff, 16'h1122);
    i2c_rd(8'hff, 3, 32'h00112200);
    tally_and_finish();
  end
  initial begin
    #3000000;
    err_total++;
    tally_and_finish();
  end
endmodule // shsp_sensor_host_serial_port_tb
